// File: csp_pkg.sv
// Purpose: constants for the codec serial control port
// Assumes: 16-bit control words, 7-bit register address, 9 data bits
// Notes: the control register bank itself lives outside this port
//
// Overview of operation
// - mode pin low two-wire, high three-wire
// - word is 7 address bits, 9 data
// - three-wire samples data on clock rise
// - latch-select rise captures last sixteen bits
// - two-wire slave detects start condition
// - shift seven address bits and the read/write bit, msb first
// - matching address acknowledged, data held low
// - mismatch or read bit returns idle
// - first data byte acknowledged
// - second data byte acknowledged
// - stop condition returns port to idle
// - unexpected start or stop abandons transfer
// - fixed device address 0011010
// - write to address zero restores defaults
// - reset sets registers to defaults
// - three-wire mode forces shared pin as latch
package csp_pkg;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned RADDR_W    = 7;
    localparam int unsigned RDATA_W    = 9;
    localparam int unsigned RADDR_LSB  = 9;
    localparam logic [6:0]  DEV_ADDR   = 7'h1a;   // 0011010, fixed
    localparam logic [6:0]  SOFT_RESET_TRIGGER_OFS = 7'h00;
    localparam logic [8:0]  DATA_RST   = 9'h000;
    localparam logic [2:0]  PIN_FUNC_INPUT = 3'h0;
    localparam logic [3:0]  BIT_CNT_LAST  = 4'h8;   // eight bits then ack
    localparam logic [15:0] WORD_RST   = 16'h0000;

    typedef enum logic [2:0] {
        CSP_IDLE = 3'b000,
        CSP_ADDR = 3'b001,
        CSP_AACK = 3'b011,
        CSP_BYT1 = 3'b010,
        CSP_ACK1 = 3'b110,
        CSP_BYT2 = 3'b111,
        CSP_ACK2 = 3'b101,
        CSP_WAIT = 3'b100
    } csp_state_e;
endpackage

// File: csp_sync.sv
`timescale 1ns/1ps
// Purpose: two-flop synchroniser for one pin
// Assumes: input is asynchronous to clk
// Notes: first stage feeds only the second
module csp_sync (
    input  wire logic clk,      // system clock
    input  wire logic resetn,   // async reset, active low
    input  wire logic d,        // asynchronous level
    output logic      q         // synchronised level
);
    logic meta_r;

    // plain two-stage capture
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // csp_sync

// File: csp_port.sv
`timescale 1ns/1ps
// Purpose: serial control port, three-wire and two-wire write-only slave
// Assumes: serial clock much slower than clk (sampled and edge detected)
// Notes: emits one-cycle write strobe with address and data per word
module csp_port
    import csp_pkg::*;
(
    input  wire logic               clk,                      // 20 MHz system clock
    input  wire logic               resetn,                   // async reset, active low
    input  wire logic               mode_pin,                 // low two-wire, high three-wire
    input  wire logic               serial_clock_pin,         // host serial clock
    input  wire logic               serial_data_pin_i,        // data pin level
    output logic                    serial_data_pin_o,        // data pin drive value
    output logic                    serial_data_pin_oe,       // high while pulling low
    input  wire logic               shared_latch_select_pin,  // latch select / gpio input
    input  wire logic [2:0]         pin_function_select,      // gpio function field
    output logic                    latch_select_used,        // pin acts as latch select
    output logic                    reg_wr,                   // one-cycle register write
    output logic [RADDR_W-1:0]      reg_addr,                 // register address
    output logic [RDATA_W-1:0]      reg_data,                 // register data
    output logic                    defaults_load,            // one-cycle restore defaults
    output logic                    busy                      // two-wire transfer active
);
    logic scl_s, sda_s, cs_s, mode_s;
    logic scl_d_r, sda_d_r, cs_d_r;
    logic scl_rise, scl_fall, cs_rise, start_c, stop_c;
    logic [WORD_W-1:0] shift3_r;
    logic [7:0]        shift2_r;
    logic [3:0]        cnt_r;
    logic [7:0]        byte1_r;
    logic [1:0]        settle_r;
    logic              settled;
    csp_state_e        st_r;

    // every pin passes two flops before use
    csp_sync u_scl  (.clk(clk), .resetn(resetn), .d(serial_clock_pin),        .q(scl_s));
    csp_sync u_sda  (.clk(clk), .resetn(resetn), .d(serial_data_pin_i),       .q(sda_s));
    csp_sync u_cs   (.clk(clk), .resetn(resetn), .d(shared_latch_select_pin), .q(cs_s));
    csp_sync u_mode (.clk(clk), .resetn(resetn), .d(mode_pin),                .q(mode_s));

    // delayed copies for edge finding
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_d_r <= 1'b0;
            sda_d_r <= 1'b1;
            cs_d_r  <= 1'b0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            cs_d_r  <= cs_s;
        end
    end

    // settle counter after reset
    // the sync flops leave reset low while the idle clock pin is high,
    // so the first edges after reset would look like a clock rise;
    // edges are ignored until both sync stages and the copies hold pin levels
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settle_r <= 2'h0;
        end else if (settle_r != 2'h3) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    assign settled  = (settle_r == 2'h3);

    // edge finders, gated until settled
    assign scl_rise = settled & scl_s & ~scl_d_r;
    assign scl_fall = settled & ~scl_s & scl_d_r;
    assign cs_rise  = settled & cs_s & ~cs_d_r;
    // start detect, data falls with clock high
    assign start_c  = settled & ~mode_s & scl_s & scl_d_r & sda_d_r & ~sda_s;
    // stop detect, data rises with clock high
    assign stop_c   = settled & ~mode_s & scl_s & scl_d_r & ~sda_d_r & sda_s;

    // latch role forced whenever three-wire selected
    // the field only matters in two-wire mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_select_used <= 1'b0;
        end else begin
            latch_select_used <= mode_s | (pin_function_select == PIN_FUNC_INPUT);
        end
    end

    // three-wire shift, msb arrives first
    // no bit count: the latch edge simply takes the last sixteen bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift3_r <= WORD_RST;
        end else if (mode_s && scl_rise) begin
            shift3_r <= {shift3_r[WORD_W-2:0], sda_s};
        end
    end

    // two-wire engine runs only with mode low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r     <= CSP_IDLE;
            cnt_r    <= 4'h0;
            shift2_r <= 8'h00;
            byte1_r  <= 8'h00;
        end else if (mode_s) begin
            st_r <= CSP_IDLE;
        end else if (start_c) begin
            st_r  <= CSP_ADDR;
            cnt_r <= 4'h0;
        end else if (stop_c) begin
            st_r <= CSP_IDLE;
        end else begin
            case (st_r)
                CSP_ADDR, CSP_BYT1, CSP_BYT2: begin
                    // shift eight bits on clock rise
                    if (scl_rise) begin
                        shift2_r <= {shift2_r[6:0], sda_s};
                        cnt_r    <= cnt_r + 4'h1;
                    end
                    if (scl_fall && cnt_r == BIT_CNT_LAST) begin
                        cnt_r <= 4'h0;
                        if (st_r == CSP_ADDR) begin
                            // match own address and write bit
                            if (shift2_r[7:1] == DEV_ADDR && !shift2_r[0]) st_r <= CSP_AACK;
                            else st_r <= CSP_IDLE;
                        end else if (st_r == CSP_BYT1) begin
                            byte1_r <= shift2_r;
                            st_r    <= CSP_ACK1;
                        end else begin
                            st_r <= CSP_ACK2;
                        end
                    end
                end
                // ack phases end at the falling edge of the ninth clock
                CSP_AACK: if (scl_fall) st_r <= CSP_BYT1;
                CSP_ACK1: if (scl_fall) st_r <= CSP_BYT2;
                CSP_ACK2: if (scl_fall) st_r <= CSP_WAIT;
                CSP_WAIT: st_r <= CSP_WAIT;   // idle until stop or start
                default:  st_r <= CSP_IDLE;
            endcase
        end
    end

    // pull data low through each ack slot
    // release comes with the falling edge that ends the slot, so the
    // host never sees data move while its clock is high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serial_data_pin_oe <= 1'b0;
        end else begin
            serial_data_pin_oe <= ~mode_s & ~start_c & ~stop_c &
                ((st_r == CSP_AACK) | (st_r == CSP_ACK1) | (st_r == CSP_ACK2)) & ~scl_fall;
        end
    end

    // open-drain: only ever drives low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serial_data_pin_o <= 1'b0;
        end else begin
            serial_data_pin_o <= 1'b0;
        end
    end

    // busy mirrors an active two-wire transfer
    // wait state counts as idle, the word is already delivered there
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
        end else begin
            busy <= (st_r != CSP_IDLE) && (st_r != CSP_WAIT);
        end
    end

    // word delivery; address zero restores defaults
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_wr        <= 1'b0;
            reg_addr      <= SOFT_RESET_TRIGGER_OFS;
            reg_data      <= DATA_RST;
            defaults_load <= 1'b1;   // defaults asserted through reset
        end else begin
            reg_wr        <= 1'b0;
            defaults_load <= 1'b0;
            if (mode_s && cs_rise) begin
                reg_wr        <= 1'b1;
                reg_addr      <= shift3_r[WORD_W-1:RADDR_LSB];
                reg_data      <= shift3_r[RDATA_W-1:0];
                defaults_load <= (shift3_r[WORD_W-1:RADDR_LSB] == SOFT_RESET_TRIGGER_OFS);
            end else if (!mode_s && !start_c && !stop_c && st_r == CSP_ACK2 && scl_fall) begin
                reg_wr        <= 1'b1;
                reg_addr      <= byte1_r[7:1];
                reg_data      <= {byte1_r[0], shift2_r};
                defaults_load <= (byte1_r[7:1] == SOFT_RESET_TRIGGER_OFS);
            end
        end
    end
endmodule // csp_port

// File: csp_port_sva.sv
// Purpose: port timing checker
// Assumes: bound into csp_port
// Notes: pins pass sync flops, so bounds allow slack
`timescale 1ns/1ps
module csp_port_sva
    import csp_pkg::*;
(
    input wire logic               clk,                 // clock
    input wire logic               resetn,              // reset
    input wire logic               mode_pin,            // mode
    input wire logic               serial_clock_pin,    // sclk
    input wire logic               serial_data_pin_i,   // wire
    input wire logic               serial_data_pin_o,   // drive
    input wire logic               serial_data_pin_oe,  // pull
    input wire logic               latch_select_used,   // role
    input wire logic               reg_wr,              // strobe
    input wire logic [RADDR_W-1:0] reg_addr,            // address
    input wire logic               defaults_load,       // restore
    input wire logic               busy                 // active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // stop: data rises with clock high
    sequence stop_s;
        serial_clock_pin && $rose(serial_data_pin_i);
    endsequence
    pin_role_a: assert property (mode_pin [*5] |-> latch_select_used and !busy)
        else $error("three-wire pin role");
    drive_low_a: assert property (serial_data_pin_oe |-> !serial_data_pin_o && busy)
        else $error("ack drive");
    ack_hold_a: assert property ($rose(serial_data_pin_oe) |-> serial_data_pin_oe [*6])
        else $error("ack short");
    ack_end_a: assert property ($rose(serial_data_pin_oe) |-> ##[6:12] !serial_data_pin_oe)
        else $error("ack long");
    wr_pulse_a: assert property (reg_wr |=> !reg_wr)
        else $error("strobe width");
    zero_reset_a: assert property (reg_wr && reg_addr == 7'h00 |-> defaults_load)
        else $error("no restore");
    only_zero_a: assert property (defaults_load && $past(resetn) |-> reg_wr && reg_addr == 7'h00)
        else $error("stray restore");
    stop_idle_a: assert property (stop_s |-> ##[1:6] !busy)
        else $error("busy after stop");
endmodule // csp_port_sva

// File: csp_host.sv
// Purpose: host driving the serial control pins
// Assumes: data wire is open drain with pull-up
// Notes: clock stands still between frames
`timescale 1ns/1ps
module csp_host (
    input  wire logic clk,    // bench clock
    input  wire logic sda_w,  // resolved data wire
    output logic      scl,    // serial clock
    output logic      sda,    // data, 1 releases
    output logic      cs      // latch select
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        cs = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // msb first, data moves while clock low
    task automatic bit1(input logic b);
        tick(1);
        sda <= b;
        tick(3);
        scl <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    // release, sample ack, wait out the pull
    task automatic byte2(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bit1(b[i]);
        tick(1);
        sda <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(2);
        ack = !sda_w;
        tick(2);
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic send2(input logic [7:0] dev, input logic [15:0] w, output logic [2:0] a);
        sda <= 1'b0;
        tick(4);
        scl <= 1'b0;
        byte2(dev, a[2]);
        byte2(w[15:8], a[1]);
        byte2(w[7:0], a[0]);
        // stop: data low under low clock, clock up, then data rises
        tick(1);
        sda <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda <= 1'b1;
        tick(8);
    endtask
    task automatic send3(input logic [15:0] w);
        scl <= 1'b0;
        for (int i = 15; i >= 0; i--) bit1(w[i]);
        tick(4);
        cs <= 1'b1;
        tick(8);
        cs <= 1'b0;
        sda <= ~w[0];
        tick(1);
    endtask
endmodule // csp_host

// File: testbench.sv
// Purpose: self-checking bench for csp_port
// Assumes: host model drives both formats
// Notes: writes are queued by the driver and matched by a monitor
`timescale 1ns/1ps
module testbench import csp_pkg::*;;
    logic clk, resetn, mode, scl, sda_h, cs, lsu, wr, dl, oe, o_d, busy;
    logic [2:0] pfs, acks;
    logic [6:0] addr;
    logic [8:0] data;
    logic [15:0] q[$];
    logic [15:0] w, e;
    int miscompares, n_compared, cycles, seed;
    // open drain: device pull wins over release
    wire sda_w = sda_h & ~oe;
    csp_port dut (.clk(clk), .resetn(resetn), .mode_pin(mode), .serial_clock_pin(scl),
        .serial_data_pin_i(sda_w), .serial_data_pin_o(o_d), .serial_data_pin_oe(oe),
        .shared_latch_select_pin(cs), .pin_function_select(pfs), .latch_select_used(lsu),
        .reg_wr(wr), .reg_addr(addr), .reg_data(data), .defaults_load(dl), .busy(busy));
    csp_host host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda_h), .cs(cs));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
        n_compared++;
        if (s !== x) begin
            miscompares++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // monitor: each strobe takes the oldest note
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            finish_test();
        end
        if (wr === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : 16'hxxxx;
            check("word", {addr, data}, e);
            check("restore", 16'(dl), 16'(e[15:9] == 7'h00));
        end
    end
    initial begin
        seed = 87;
        mode = 1'b0;
        pfs = 3'h0;
        resetn = 1'b0;
        repeat (20) @(posedge clk);
        check("por", 16'(dl), 16'h0001);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        // good, zero address, wrong address, read bit
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            if (i == 1) w[15:9] = 7'h00;
            if (i < 2) q.push_back(w);
            host.send2(i == 2 ? 8'h36 : i == 3 ? 8'h35 : 8'h34, w, acks);
            check("acks", 16'(acks), i < 2 ? 16'h0007 : 16'h0000);
        end
        mode <= 1'b1;
        pfs <= 3'($random(seed)) | 3'h1;
        repeat (6) @(posedge clk);
        check("latch_role", 16'(lsu), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            w = $random(seed);
            if (i == 2) w[15:9] = 7'h00;
            q.push_back(w);
            host.send3(w);
        end
        mode <= 1'b0;
        repeat (6) @(posedge clk);
        check("gpio_role", 16'(lsu), 16'h0000);
        check("left_over", 16'(q.size()), 16'h0000);
        finish_test();
    end
endmodule // testbench
bind csp_port csp_port_sva u_sva (.*);
